// [core/hesu_hdlc_event_status_unit.sv]
// Purpose: Event, enable and line status registers of an HDLC channel.
// Assumes: Channel datapath strobes are one-cycle pulses on clk.
// Notes: APB slave with one wait-free access phase.
//
// How it works
// - A 16-bit event register latches each recognised channel event.
// - Events read anytime; write one clears, zero keeps; reset to zero.
// - Interrupt request stays high while any enabled event bit is set.
// - Event bits at fixed positions; reserved bits 15-13, 6, 5 stay zero.
// - Clock glitches on receive or transmit clock set their event bits.
// - Any change of DPLL carrier sense sets the carrier change event.
// - Start and stop of flag reception each set the flag event.
// - Each change of line idle status sets the idle event.
// - Graceful stop event after current frame ends, or at once.
// - Underrun or clear-to-send loss during transmit sets transmit error.
// - Frame received event set at least two clocks after closing flag.
// - Frame discarded for lack of buffers sets the busy event.
// - Transmit buffer event timed by closing flag or FIFO load.
// - Receive buffer closed without frame end sets receive buffer event.
// - A 16-bit read-write enable register gates events; resets to zero.
// - An 8-bit read-only status register; bits 7-3 read zero.
// - Flag status searches each bit, holds eight bits, then rechecks.
// - Flag search uses the DPLL-decoded receive bits.
// - Carrier sense status shows the DPLL carrier in real time.
// - Idle status after 15 ones, cleared by the first zero.
// - Clear-to-send loss is reported to the open transmit descriptor.
// - Exactly the descriptor byte count is sent; count is never rewritten.
// - Receive descriptor interrupt flag gates only the receive buffer event.
// - Transmit descriptor interrupt flag gates transmit buffer and error.
`timescale 1ns/10ps
module hesu_hdlc_event_status_unit
	import hesu_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_clock_glitch,
	input wire logic tx_clock_glitch,
	input wire logic dpll_carrier,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic graceful_stop_cmd,
	input wire logic tx_frame_active,
	input wire logic tx_underrun,
	input wire logic clear_to_send_lost,
	input wire logic rx_frame_done,
	input wire logic rx_buffer_missing,
	input wire logic rx_bd_close,
	input wire logic rx_bd_frame_end,
	input wire logic rx_bd_int,
	input wire logic tx_buf_fifo_loaded,
	input wire logic tx_close_flag_last,
	input wire logic tx_bd_last,
	input wire logic tx_bd_int,
	input wire logic tx_bd_load,
	input wire logic [15:0] tx_bd_length,
	input wire logic tx_byte_taken,
	output logic irq_q,
	output logic bd_cts_lost_q,
	output logic [15:0] tx_bytes_left_q,
	output logic tx_buf_drained_q
);
	// ****************************************
	// State
	// ****************************************
	logic [15:0] ev_q;
	logic [15:0] ev_d;
	logic [15:0] ev_set;
	logic [15:0] ev_clr;
	logic [15:0] en_q;
	logic carrier_q;
	logic flag_prev_q;
	logic idle_prev_q;
	logic [HESU_RXF_DELAY_CLKS-1:0] rxf_pipe_q;
	hesu_gs_e gs_q;
	hesu_gs_e gs_d;
	logic gs_done;
	logic flag_status;
	logic line_idle;
	logic tx_error;
	logic [15:0] left_d;

	// ****************************************
	// APB decode
	// ****************************************
	logic access;
	logic wr_ev;
	logic wr_en;
	logic hit_ev;
	logic hit_en;
	logic hit_st;
	logic hit_any;
	logic [31:0] rd_data;
	logic [7:0] status_byte;

	assign access = psel && penable && pready;
	assign hit_ev = (paddr == HESU_OFS_EVENTS);
	assign hit_en = (paddr == HESU_OFS_ENABLE);
	assign hit_st = (paddr == HESU_OFS_STATUS);
	assign hit_any = hit_ev || hit_en || hit_st;
	assign wr_ev = access && pwrite && hit_ev;
	assign wr_en = access && pwrite && hit_en;
	assign status_byte = {5'h00, flag_status, carrier_q, line_idle};
	assign rd_data = hit_ev ? {16'h0000, ev_q} :
		hit_en ? {16'h0000, en_q} :
		hit_st ? {24'h000000, status_byte} : 32'h00000000;

	// Ready rises in the first access cycle, so every transfer is two cycles.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit_any;
			prdata <= (psel && !penable && !pwrite) ? rd_data : 32'h00000000;
		end
	end

	// ****************************************
	// Line monitor
	// ****************************************
	hesu_line_monitor u_line (
		.clk(clk),
		.rst(rst),
		.rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit),
		.flag_status_q(flag_status),
		.line_idle_q(line_idle)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carrier_q <= 1'b0;
			flag_prev_q <= 1'b0;
			idle_prev_q <= 1'b0;
			rxf_pipe_q <= '0;
		end else begin
			carrier_q <= dpll_carrier;
			flag_prev_q <= flag_status;
			idle_prev_q <= line_idle;
			rxf_pipe_q <= {rxf_pipe_q[HESU_RXF_DELAY_CLKS-2:0], rx_frame_done};
		end
	end

	// ****************************************
	// Graceful stop
	// ****************************************
	// A command that arrives while waiting is absorbed by the same wait.
	always_comb begin
		gs_d = gs_q;
		gs_done = 1'b0;
		unique case (gs_q)
			HESU_GS_IDLE: begin
				if (graceful_stop_cmd && tx_frame_active) begin
					gs_d = HESU_GS_WAIT;
				end else if (graceful_stop_cmd) begin
					gs_done = 1'b1;
				end
			end
			HESU_GS_WAIT: begin
				if (!tx_frame_active) begin
					gs_d = HESU_GS_IDLE;
					gs_done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gs_q <= HESU_GS_IDLE;
		end else begin
			gs_q <= gs_d;
		end
	end

	// ****************************************
	// Event register
	// ****************************************
	assign tx_error = tx_bd_int &&
		(tx_underrun || (clear_to_send_lost && tx_frame_active));

	always_comb begin
		ev_set = 16'h0000;
		ev_set[HESU_EV_GLR] = rx_clock_glitch;
		ev_set[HESU_EV_GLT] = tx_clock_glitch;
		ev_set[HESU_EV_DCC] = carrier_q != dpll_carrier;
		ev_set[HESU_EV_FLG] = flag_prev_q != flag_status;
		ev_set[HESU_EV_IDL] = idle_prev_q != line_idle;
		ev_set[HESU_EV_GRA] = gs_done;
		ev_set[HESU_EV_TXE] = tx_error;
		ev_set[HESU_EV_RXF] = rxf_pipe_q[HESU_RXF_DELAY_CLKS-1];
		ev_set[HESU_EV_BSY] = rx_buffer_missing;
		ev_set[HESU_EV_TXB] = tx_bd_int && !tx_error &&
			(tx_bd_last ? tx_close_flag_last : tx_buf_fifo_loaded);
		ev_set[HESU_EV_RXB] = rx_bd_close && !rx_bd_frame_end &&
			rx_bd_int;
	end

	// A new event in the clearing cycle survives: set is ORed after clear.
	assign ev_clr = wr_ev ? pwdata[15:0] : 16'h0000;
	assign ev_d = ((ev_q & ~ev_clr) | ev_set) & HESU_EV_USED;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ev_q <= HESU_EV_RESET;
			en_q <= HESU_EN_RESET;
			irq_q <= 1'b0;
		end else begin
			ev_q <= ev_d;
			if (wr_en) begin
				en_q <= pwdata[15:0] & HESU_EV_USED;
			end
			irq_q <= |(ev_q & en_q);
		end
	end

	// ****************************************
	// Transmit descriptor support
	// ****************************************
	// The length field is only read; the countdown lives in a copy.
	assign left_d = tx_bd_load ? tx_bd_length :
		(tx_byte_taken && tx_bytes_left_q != 16'h0000) ?
		tx_bytes_left_q - 16'h0001 : tx_bytes_left_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bd_cts_lost_q <= 1'b0;
			tx_bytes_left_q <= 16'h0000;
			tx_buf_drained_q <= 1'b1;
		end else begin
			bd_cts_lost_q <= clear_to_send_lost && tx_frame_active;
			tx_bytes_left_q <= left_d;
			tx_buf_drained_q <= (left_d == 16'h0000);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_w1c_clear: assert property (
		(wr_ev && pwdata[HESU_EV_BSY] && !ev_set[HESU_EV_BSY])
		|=> !ev_q[HESU_EV_BSY])
		else $error("busy event not cleared by write one");
	chk_set_wins: assert property (
		(wr_ev && rx_buffer_missing) |=> ev_q[HESU_EV_BSY])
		else $error("event lost in its clearing cycle");
	chk_irq_or: assert property (
		##1 (irq_q == |($past(ev_q) & $past(en_q))))
		else $error("interrupt request does not match enabled events");
	chk_irq_holds: assert property (
		(|(ev_q & en_q)) |=> irq_q)
		else $error("interrupt dropped with enabled event pending");
	chk_rxf_delay: assert property (
		rx_frame_done |-> ##3 ev_q[HESU_EV_RXF])
		else $error("frame event not set three clocks after done");
	chk_gra_at_once: assert property (
		(graceful_stop_cmd && !tx_frame_active && gs_q == HESU_GS_IDLE)
		|=> ev_q[HESU_EV_GRA])
		else $error("graceful stop not reported at once");
	chk_carrier_event: assert property (
		(dpll_carrier != carrier_q) |=> ev_q[HESU_EV_DCC])
		else $error("carrier change not recorded");
	chk_reserved_zero: assert property (
		(ev_q & ~HESU_EV_USED) == 16'h0000)
		else $error("reserved event bit set");
	chk_enable_write: assert property (
		wr_en |=> en_q == ($past(pwdata[15:0]) & HESU_EV_USED))
		else $error("enable register write not stored");
	chk_idle_clear: assert property (
		(rx_bit_valid && !rx_bit) |=> !line_idle)
		else $error("idle status kept after a zero");
	chk_len_load: assert property (
		tx_bd_load |=> tx_bytes_left_q == $past(tx_bd_length))
		else $error("byte count not loaded from descriptor");

	cov_irq_raised: cover property (!irq_q ##1 irq_q);
	cov_gra_waited: cover property (
		gs_q == HESU_GS_WAIT ##1 ev_q[HESU_EV_GRA]);
	cov_flag_seen: cover property (!flag_status ##1 flag_status);
	cov_idle_seen: cover property (!line_idle ##1 line_idle);
endmodule // hesu_hdlc_event_status_unit

// [core/hesu_line_monitor.sv]
// Purpose: Flag and idle detection on the decoded receive bit stream.
// Assumes: rx_bit_valid pulses once per bit time after DPLL decoding.
// Notes: Both outputs are registered.
`timescale 1ns/10ps
module hesu_line_monitor
	import hesu_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	output logic flag_status_q,
	output logic line_idle_q
);
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [3:0] hold_q;
	logic [3:0] ones_q;
	logic is_flag;
	logic hold_done;

	assign shift_d = {shift_q[6:0], rx_bit};
	assign is_flag = (shift_d == HESU_FLAG_PATTERN);
	assign hold_done = (hold_q == HESU_FLAG_HOLD_BITS - 4'h1);

	// The window slides every bit time so a flag at any alignment is seen.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_q <= 8'h00;
			hold_q <= 4'h0;
			flag_status_q <= 1'b0;
		end else if (rx_bit_valid) begin
			shift_q <= shift_d;
			if (!flag_status_q) begin
				flag_status_q <= is_flag;
				hold_q <= 4'h0;
			end else if (hold_done) begin
				flag_status_q <= is_flag;
				hold_q <= 4'h0;
			end else begin
				hold_q <= hold_q + 4'h1;
			end
		end
	end

	// Ones saturate at the idle count; a single zero ends idle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ones_q <= 4'h0;
			line_idle_q <= 1'b0;
		end else if (rx_bit_valid) begin
			if (!rx_bit) begin
				ones_q <= 4'h0;
				line_idle_q <= 1'b0;
			end else if (ones_q != HESU_IDLE_ONES) begin
				ones_q <= ones_q + 4'h1;
				line_idle_q <= (ones_q == HESU_IDLE_ONES - 4'h1);
			end
		end
	end
endmodule // hesu_line_monitor

// [core/hesu_pkg.sv]
// Purpose: Shared constants for the HDLC event and line status unit.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Bit positions follow the event register layout.
package hesu_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] HESU_OFS_EVENTS = 8'h00;
	localparam logic [7:0] HESU_OFS_ENABLE = 8'h04;
	localparam logic [7:0] HESU_OFS_STATUS = 8'h08;
	localparam logic [15:0] HESU_EV_RESET = 16'h0000;
	localparam logic [15:0] HESU_EN_RESET = 16'h0000;
	// Implemented event bits; bits 15-13, 6 and 5 stay zero.
	localparam logic [15:0] HESU_EV_USED = 16'h1f9f;
	// ****************************************
	// Event bit positions
	// ****************************************
	localparam int HESU_EV_RXB = 0;
	localparam int HESU_EV_TXB = 1;
	localparam int HESU_EV_BSY = 2;
	localparam int HESU_EV_RXF = 3;
	localparam int HESU_EV_TXE = 4;
	localparam int HESU_EV_GRA = 7;
	localparam int HESU_EV_IDL = 8;
	localparam int HESU_EV_FLG = 9;
	localparam int HESU_EV_DCC = 10;
	localparam int HESU_EV_GLT = 11;
	localparam int HESU_EV_GLR = 12;
	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int HESU_ST_IDLE = 0;
	localparam int HESU_ST_CS = 1;
	localparam int HESU_ST_FLAG = 2;
	// ****************************************
	// Line timing, in bit times and clocks
	// ****************************************
	localparam logic [7:0] HESU_FLAG_PATTERN = 8'h7e;
	localparam logic [3:0] HESU_FLAG_HOLD_BITS = 4'h8;
	localparam logic [3:0] HESU_IDLE_ONES = 4'hf;
	localparam int HESU_RXF_DELAY_CLKS = 2;
	// ****************************************
	// Graceful stop state
	// ****************************************
	typedef enum logic {
		HESU_GS_IDLE = 1'b0,
		HESU_GS_WAIT = 1'b1
	} hesu_gs_e;
endpackage

// [testbench/hesu_hdlc_event_status_unit_tb.sv]
// Purpose: Self-checking bench for the HDLC event and line status unit.
// Assumes: Zero-wait APB slave; event strobes are one-cycle pulses.
// Notes: Pulse inputs share one vector so a table can drive them.
`timescale 1ns/10ps
module hesu_hdlc_event_status_unit_tb
	import hesu_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, acc;
	logic pready, pslverr, er, go = 1'b0, cts_seen = 1'b0;
	logic [11:0] pin = 12'h000;
	logic dpll_carrier = 1'b0, tx_frame_active = 1'b0;
	logic rx_bd_frame_end = 1'b0, rx_bd_int = 1'b1;
	logic tx_bd_last = 1'b0, tx_bd_int = 1'b1;
	logic [15:0] tx_bd_length = 16'h0003, tx_bytes_left_q;
	logic irq_q, bd_cts_lost_q, tx_buf_drained_q, rx_bit_valid, rx_bit, busy;
	logic [31:0] frame = 32'h0;
	logic [5:0] nbits = 6'h00;
	int fails = 0, cmp_count = 0;
	int evpin[8] = '{0, 1, 6, 5, 3, 2, 7, 8};
	int evbit[8] = '{HESU_EV_GLR, HESU_EV_GLT, HESU_EV_BSY, HESU_EV_RXF,
		HESU_EV_TXE, HESU_EV_GRA, HESU_EV_RXB, HESU_EV_TXB};
	always #12.5 clk = ~clk;
	always @(posedge clk) if (bd_cts_lost_q === 1'b1) cts_seen <= 1'b1;
	hesu_hdlc_event_status_unit dut_u (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_clock_glitch(pin[0]), .tx_clock_glitch(pin[1]),
		.dpll_carrier(dpll_carrier), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .graceful_stop_cmd(pin[2]),
		.tx_frame_active(tx_frame_active), .tx_underrun(pin[3]),
		.clear_to_send_lost(pin[4]), .rx_frame_done(pin[5]),
		.rx_buffer_missing(pin[6]), .rx_bd_close(pin[7]),
		.rx_bd_frame_end(rx_bd_frame_end), .rx_bd_int(rx_bd_int),
		.tx_buf_fifo_loaded(pin[8]), .tx_close_flag_last(pin[9]),
		.tx_bd_last(tx_bd_last), .tx_bd_int(tx_bd_int), .tx_bd_load(pin[10]),
		.tx_bd_length(tx_bd_length), .tx_byte_taken(pin[11]),
		.irq_q(irq_q), .bd_cts_lost_q(bd_cts_lost_q),
		.tx_bytes_left_q(tx_bytes_left_q), .tx_buf_drained_q(tx_buf_drained_q));
	hesu_remote_station far_u (.clk(clk), .rst(rst), .go(go), .frame(frame),
		.nbits(nbits), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.busy(busy));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic pulse(input int i, input int w);
		@(posedge clk);
		pin[i] <= 1'b1;
		@(posedge clk);
		pin[i] <= 1'b0;
		repeat (w) @(posedge clk);
	endtask
	task automatic send(input logic [31:0] f, input logic [5:0] nb);
		int n;
		n = 0;
		@(posedge clk);
		frame <= f;
		nbits <= nb;
		go <= 1'b1;
		@(posedge clk);
		go <= 0;
		do begin
			@(posedge clk);
			n++;
		end while (busy === 1'b1 && n < 300);
		if (n >= 300) begin
			fails++;
			tally_and_finish();
		end
		repeat (4) @(posedge clk);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rdchk(HESU_OFS_EVENTS, 32'h0);
		rdchk(HESU_OFS_ENABLE, 32'h0);
		rdchk(HESU_OFS_STATUS, 32'h0);
		apb(1'b1, HESU_OFS_ENABLE, 32'hffff);
		rdchk(HESU_OFS_ENABLE, {16'h0, HESU_EV_USED});
		apb(1'b1, 8'h0c, 32'h0);
		chk({31'h0, er}, 32'h1);
		rdchk(HESU_OFS_ENABLE, {16'h0, HESU_EV_USED});
		apb(1'b1, HESU_OFS_STATUS, 32'hff);
		rdchk(HESU_OFS_STATUS, 32'h0);
		apb(1'b1, HESU_OFS_ENABLE, 32'h0);
		$display("test registers done");
		acc = 32'h0;
		for (int k = 0; k < 8; k++) begin
			pulse(evpin[k], 5);
			acc = acc | (32'h1 << evbit[k]);
			rdchk(HESU_OFS_EVENTS, acc);
		end
		chk({31'h0, irq_q}, 32'h0);
		apb(1'b1, HESU_OFS_EVENTS, 32'h1800);
		rdchk(HESU_OFS_EVENTS, acc & ~32'h1800);
		apb(1'b1, HESU_OFS_EVENTS, 32'h0);
		rdchk(HESU_OFS_EVENTS, acc & ~32'h1800);
		apb(1'b1, HESU_OFS_EVENTS, {16'h0, HESU_EV_USED});
		rdchk(HESU_OFS_EVENTS, 32'h0);
		$display("test events done");
		apb(1'b1, HESU_OFS_ENABLE, 32'h8);
		pulse(6, 4);
		chk({31'h0, irq_q}, 32'h0);
		pulse(5, 6);
		chk({31'h0, irq_q}, 32'h1);
		apb(1'b1, HESU_OFS_EVENTS, 32'h4);
		repeat (3) @(posedge clk);
		chk({31'h0, irq_q}, 32'h1);
		apb(1'b1, HESU_OFS_EVENTS, 32'h8);
		repeat (3) @(posedge clk);
		chk({31'h0, irq_q}, 32'h0);
		$display("test interrupt done");
		tx_frame_active <= 1'b1;
		pulse(2, 4);
		pulse(4, 4);
		rdchk(HESU_OFS_EVENTS, 32'h1 << HESU_EV_TXE);
		chk({31'h0, cts_seen}, 32'h1);
		tx_frame_active <= 1'b0;
		repeat (4) @(posedge clk);
		rdchk(HESU_OFS_EVENTS, 32'h90);
		apb(1'b1, HESU_OFS_EVENTS, {16'h0, HESU_EV_USED});
		$display("test graceful stop done");
		dpll_carrier <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk(HESU_OFS_STATUS, 32'h2);
		rdchk(HESU_OFS_EVENTS, 32'h1 << HESU_EV_DCC);
		send(32'h7e, 6'd8);
		rdchk(HESU_OFS_STATUS, 32'h6);
		send(32'hffff, 6'd16);
		rdchk(HESU_OFS_STATUS, 32'h3);
		rdchk(HESU_OFS_EVENTS, 32'h700);
		send(32'h0, 6'd1);
		rdchk(HESU_OFS_STATUS, 32'h2);
		$display("test line status done");
		chk({31'h0, tx_buf_drained_q}, 32'h1);
		pulse(10, 2);
		chk({16'h0, tx_bytes_left_q}, 32'h3);
		for (int k = 0; k < 3; k++) pulse(11, 2);
		chk({16'h0, tx_bytes_left_q}, 32'h0);
		chk({31'h0, tx_buf_drained_q}, 32'h1);
		$display("test byte count done");
		tally_and_finish();
	end
endmodule // hesu_hdlc_event_status_unit_tb

// [testbench/hesu_remote_station.sv]
// Purpose: Far-end station feeding decoded receive bits to the unit.
// Assumes: One bit every four clocks, oldest bit first.
// Notes: Between bits the data line toggles, so a stale value never helps.
`timescale 1ns/10ps
module hesu_remote_station (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [31:0] frame,
	input wire logic [5:0] nbits,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic busy
);
	logic [31:0] sh_q;
	logic [5:0] left_q;
	logic [1:0] div_q;
	assign busy = (left_q != 6'h00);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_q <= 32'h0;
			left_q <= 6'h00;
			div_q <= 2'h0;
			rx_bit_valid <= 1'b0;
			rx_bit <= 1'b0;
		end else begin
			rx_bit_valid <= 1'b0;
			rx_bit <= ~rx_bit;
			if (go && !busy) begin
				sh_q <= frame;
				left_q <= nbits;
				div_q <= 2'h0;
			end else if (busy) begin
				div_q <= div_q + 2'h1;
				if (div_q == 2'h3) begin
					rx_bit_valid <= 1'b1;
					rx_bit <= sh_q[0];
					sh_q <= sh_q >> 1;
					left_q <= left_q - 6'h01;
				end
			end
		end
	end
endmodule // hesu_remote_station
